// >>> verilog/eqs_pkg.sv
// Package: register map, field layout and constants of the egress scheduler
package eqs_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] EQS_P2_Q3_OFF = 8'hB3;
  localparam logic [7:0] EQS_P2_Q2_OFF = 8'hB4;
  localparam logic [7:0] EQS_P2_Q1_OFF = 8'hB5;
  localparam logic [7:0] EQS_P2_Q0_OFF = 8'hB6;
  localparam logic [7:0] EQS_P3_Q3_OFF = 8'hB7;
  localparam logic [7:0] EQS_P3_Q2_OFF = 8'hB8;
  localparam logic [7:0] EQS_P3_Q1_OFF = 8'hB9;
  localparam logic [7:0] EQS_P3_Q0_OFF = 8'hBA;
  localparam int unsigned EQS_REGS_PER_PORT = 4;
  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int unsigned EQS_SEL_BIT = 7;
  localparam logic        EQS_SEL_RST = 1'b1;
  localparam logic [6:0]  EQS_WT_Q3   = 7'h08;
  localparam logic [6:0]  EQS_WT_Q2   = 7'h04;
  localparam logic [6:0]  EQS_WT_Q1   = 7'h02;
  localparam logic [6:0]  EQS_WT_Q0   = 7'h01;
  localparam logic [3:0]  EQS_CR_Q3   = 4'h8;
  localparam logic [3:0]  EQS_CR_Q2   = 4'h4;
  localparam logic [3:0]  EQS_CR_Q1   = 4'h2;
  localparam logic [3:0]  EQS_CR_Q0   = 4'h1;
  localparam logic [3:0]  EQS_CR_2Q_HI = 4'h2;
  localparam logic [3:0]  EQS_CR_2Q_LO = 4'h1;
endpackage

// >>> verilog/eqs_top.sv
// Egress queue scheduling registers and arbiters for switch ports 2 and 3
// How it works
// - All four select bits set in four-queue mode: weighted service 8:4:2:1.
// - Two-queue operation with weighted selection serves high and low 2:1.
// - All select bits clear: the port uses strict priority.
// - Strict priority also needs global mode bit clear; higher queue always first.
// - Select bit is read/write at bit 7 and resets to one.
// - Ports 2 and 3 each own four queue registers, queue three first.
`timescale 1ns/1ns
module eqs_top
  import eqs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Global queue-mode bit (register 5 bit 3), kept elsewhere
  input  wire logic       strict_mode_n,
  // Per port: four or two egress queues in use
  input  wire logic       p2_four_queue,
  input  wire logic       p3_four_queue,
  // Pending frames per queue, bit 3 is highest queue
  input  wire logic [3:0] p2_pending,
  input  wire logic [3:0] p3_pending,
  input  wire logic       p2_grant_req,
  input  wire logic       p3_grant_req,
  output logic      [3:0] p2_grant,
  output logic      [3:0] p3_grant
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n_q;

  // Async assert, synchronous release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Select bit storage, one bit per queue per port
  // ****************************************************************
  logic [3:0] p2_sel_q;
  logic [3:0] p3_sel_q;
  logic [7:0] rdata_d;

  // Only bit 7 is writable; the weight field is constant
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      p2_sel_q <= {4{EQS_SEL_RST}};
      p3_sel_q <= {4{EQS_SEL_RST}};
    end else if (reg_wr) begin
      unique case (reg_addr)
        EQS_P2_Q3_OFF: p2_sel_q[3] <= reg_wdata[EQS_SEL_BIT];
        EQS_P2_Q2_OFF: p2_sel_q[2] <= reg_wdata[EQS_SEL_BIT];
        EQS_P2_Q1_OFF: p2_sel_q[1] <= reg_wdata[EQS_SEL_BIT];
        EQS_P2_Q0_OFF: p2_sel_q[0] <= reg_wdata[EQS_SEL_BIT];
        EQS_P3_Q3_OFF: p3_sel_q[3] <= reg_wdata[EQS_SEL_BIT];
        EQS_P3_Q2_OFF: p3_sel_q[2] <= reg_wdata[EQS_SEL_BIT];
        EQS_P3_Q1_OFF: p3_sel_q[1] <= reg_wdata[EQS_SEL_BIT];
        EQS_P3_Q0_OFF: p3_sel_q[0] <= reg_wdata[EQS_SEL_BIT];
        default: ;
      endcase
    end
  end

  // Read mux: select bit over fixed weight, unmapped reads zero
  always_comb begin
    unique case (reg_addr)
      EQS_P2_Q3_OFF: rdata_d = {p2_sel_q[3], EQS_WT_Q3};
      EQS_P2_Q2_OFF: rdata_d = {p2_sel_q[2], EQS_WT_Q2};
      EQS_P2_Q1_OFF: rdata_d = {p2_sel_q[1], EQS_WT_Q1};
      EQS_P2_Q0_OFF: rdata_d = {p2_sel_q[0], EQS_WT_Q0};
      EQS_P3_Q3_OFF: rdata_d = {p3_sel_q[3], EQS_WT_Q3};
      EQS_P3_Q2_OFF: rdata_d = {p3_sel_q[2], EQS_WT_Q2};
      EQS_P3_Q1_OFF: rdata_d = {p3_sel_q[1], EQS_WT_Q1};
      EQS_P3_Q0_OFF: rdata_d = {p3_sel_q[0], EQS_WT_Q0};
      default:       rdata_d = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the address
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Per-port arbiters
  // ****************************************************************
  eqs_arb u_p2_arb (
    .clk        (core_clk),
    .rst_n      (rst_n_q),
    .sel        (p2_sel_q),
    .strict_n   (strict_mode_n),
    .four_queue (p2_four_queue),
    .pending    (p2_pending),
    .req        (p2_grant_req),
    .grant      (p2_grant)
  );

  eqs_arb u_p3_arb (
    .clk        (core_clk),
    .rst_n      (rst_n_q),
    .sel        (p3_sel_q),
    .strict_n   (strict_mode_n),
    .four_queue (p3_four_queue),
    .pending    (p3_pending),
    .req        (p3_grant_req),
    .grant      (p3_grant)
  );

endmodule // eqs_top

// One egress port: weighted round robin or strict priority
module eqs_arb
  import eqs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] sel,
  input  wire logic       strict_n,
  input  wire logic       four_queue,
  input  wire logic [3:0] pending,
  input  wire logic       req,
  output logic      [3:0] grant
);

  logic       weighted;
  logic [3:0] active;
  logic [3:0] credit_q [4];
  logic [3:0] elig;
  logic [3:0] grant_d;
  logic [3:0] prio_pick;
  logic [3:0] wt_pick;

  // Mixed select bits are treated as weighted: strict needs all clear
  assign weighted = (sel != 4'h0) || strict_n;
  // Two-queue operation uses queues three and zero
  assign active = four_queue ? pending : (pending & 4'h9);

  // Queues still holding credit in this round, empty ones skipped
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      elig[i] = active[i] && (credit_q[i] != 4'h0);
    end
  end

  // Highest pending queue first
  always_comb begin
    prio_pick = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (active[i]) prio_pick = 4'h1 << i;
    end
    wt_pick = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (elig[i]) wt_pick = 4'h1 << i;
    end
    // Round exhausted with work left: pick as if credits refilled
    if (wt_pick == 4'h0) wt_pick = prio_pick;
    if (!req) begin
      grant_d = 4'h0;
    end else if (weighted) begin
      grant_d = wt_pick;
    end else begin
      grant_d = prio_pick;
    end
  end

  // Credits per queue; refill when no eligible queue remains
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      credit_q[3] <= EQS_CR_Q3;
      credit_q[2] <= EQS_CR_Q2;
      credit_q[1] <= EQS_CR_Q1;
      credit_q[0] <= EQS_CR_Q0;
    end else if (req && weighted && grant_d != 4'h0) begin
      if (elig == 4'h0) begin
        // New round: reload, then charge the granted queue
        for (int i = 0; i < 4; i++) begin
          if (four_queue) begin
            credit_q[i] <= (i == 3) ? EQS_CR_Q3 : (i == 2) ? EQS_CR_Q2 :
                           (i == 1) ? EQS_CR_Q1 : EQS_CR_Q0;
          end else begin
            credit_q[i] <= (i == 3) ? EQS_CR_2Q_HI : EQS_CR_2Q_LO;
          end
          if (grant_d[i]) begin
            credit_q[i] <= four_queue ?
              ((i == 3) ? EQS_CR_Q3 - 4'h1 : (i == 2) ? EQS_CR_Q2 - 4'h1 :
               (i == 1) ? EQS_CR_Q1 - 4'h1 : 4'h0) :
              ((i == 3) ? EQS_CR_2Q_HI - 4'h1 : 4'h0);
          end
        end
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (grant_d[i]) credit_q[i] <= credit_q[i] - 4'h1;
        end
      end
    end
  end

  // Grant held in a flop, valid the cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grant <= 4'h0;
    end else begin
      grant <= grant_d;
    end
  end

endmodule // eqs_arb

// >>> bench/eqs_top_properties.sv
// Checker: port-level properties of the egress scheduler
`timescale 1ns/1ns
module eqs_top_properties (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       strict_mode_n,
  input wire logic       p2_four_queue,
  input wire logic       p3_four_queue,
  input wire logic [3:0] p2_pending,
  input wire logic [3:0] p3_pending,
  input wire logic       p2_grant_req,
  input wire logic       p3_grant_req,
  input wire logic [3:0] p2_grant,
  input wire logic [3:0] p3_grant
);
  logic [1:0] rsync_q;
  logic [3:0] sel2_q;
  // Mirror the two-flop release so checks start with the design
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rsync_q <= 2'h0;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  // Port 2 select shadow; strict service is legal only when all clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) sel2_q <= 4'hF;
    else if (reg_wr && reg_addr >= 8'hB3 && reg_addr <= 8'hB6)
      sel2_q[2'(8'hB6 - reg_addr)] <= reg_wdata[7];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rsync_q[1]);
  // ********
  // Properties
  // ********
  AST_NO_REQ: assert property (!p2_grant_req |=> p2_grant == 4'h0)
    else $error("grant without request");
  AST_PENDING: assert property (p2_grant_req |=>
    (p2_grant & ~$past(p2_pending)) == 4'h0) else $error("empty granted");
  // Two-queue ports only serve queues three and zero, so mask the rest
  AST_NO_IDLE: assert property (p2_grant_req
    && (p2_pending & (p2_four_queue ? 4'hF : 4'h9)) != 4'h0
    |=> $onehot(p2_grant)) else $error("link idle");
  AST_TWO_Q: assert property (p2_grant_req && !p2_four_queue
    |=> p2_grant[2:1] == 2'h0) else $error("middle queue in two-queue");
  AST_STRICT: assert property (p2_grant_req && sel2_q == 4'h0
    && !strict_mode_n && p2_pending[3] |=> p2_grant == 4'h8)
    else $error("strict order broken");
  AST_P3_SERVED: assert property (p3_grant_req
    && (p3_pending & (p3_four_queue ? 4'hF : 4'h9)) != 4'h0
    |=> $onehot(p3_grant)) else $error("port 3 idle");
  AST_UNMAPPED: assert property (reg_addr < 8'hB3 || reg_addr > 8'hBA
    |=> reg_rdata == 8'h00) else $error("unmapped read");
  AST_Q3_READ: assert property (reg_addr == 8'hB3
    |=> reg_rdata == {$past(sel2_q[3]), 7'h08}) else $error("bad read");
endmodule // eqs_top_properties

// >>> bench/testbench.sv
// Testbench: register and scheduling checks of the egress scheduler
`timescale 1ns/1ns
module testbench;
  logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0;
  logic        strict_mode_n = 1'b1, p2_four_queue = 1'b1;
  logic        p3_four_queue = 1'b1, p2_grant_req = 1'b0;
  logic        p3_grant_req = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0]  p2_pending = 4'h0, p3_pending = 4'h0, p2_grant, p3_grant;
  logic [31:0] g2, g3;
  int          mismatches = 0, n_compared = 0, cycles = 0;
  eqs_top eqs_top_i (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .strict_mode_n (strict_mode_n),
    .p2_four_queue (p2_four_queue),
    .p3_four_queue (p3_four_queue),
    .p2_pending    (p2_pending),
    .p3_pending    (p3_pending),
    .p2_grant_req  (p2_grant_req),
    .p3_grant_req  (p3_grant_req),
    .p2_grant      (p2_grant),
    .p3_grant      (p3_grant)
  );
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  // The whole run needs some 230 cycles; stop a hang well beyond that
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Six cycles of reset, then wait out the two-flop release
  task automatic do_reset();
    nrst = 1'b0;
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // A spare cycle after each write keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge core_clk);
    chk({24'h0, reg_rdata}, {24'h0, exp});
  endtask
  // Hold requests; tally grants per queue after a settling stretch
  task automatic sched(input logic [3:0] pd2, input logic [3:0] pd3,
                       input int skip, input int n);
    logic [7:0] c2 [4] = '{default: 8'h00};
    logic [7:0] c3 [4] = '{default: 8'h00};
    p2_pending = pd2;
    p3_pending = pd3;
    p2_grant_req = 1'b1;
    p3_grant_req = 1'b1;
    repeat (skip) @(negedge core_clk);
    repeat (n) begin
      @(negedge core_clk);
      for (int i = 0; i < 4; i++) begin
        c2[i] += 8'(p2_grant[i]);
        c3[i] += 8'(p3_grant[i]);
      end
    end
    p2_grant_req = 1'b0;
    p3_grant_req = 1'b0;
    g2 = {c2[3], c2[2], c2[1], c2[0]};
    g3 = {c3[3], c3[2], c3[1], c3[0]};
    @(negedge core_clk);
  endtask
  // Main sequence; windows span whole rounds so any phase gives the ratio
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++)
      rd(8'hB3 + 8'(i), {1'b1, 7'(8 >> (i % 4))});
    rd(8'hB2, 8'h00);
    wr(8'hB4, 8'h04);
    rd(8'hB4, 8'h04);
    $display("test registers done");
    sched(4'hF, 4'hF, 15, 15);
    chk(g2, 32'h08040201);
    chk(g3, 32'h08040201);
    p2_four_queue = 1'b0;
    p3_four_queue = 1'b0;
    sched(4'hF, 4'h9, 15, 18);
    chk(g2, 32'h0C000006);
    chk(g3, 32'h0C000006);
    p2_four_queue = 1'b1;
    p3_four_queue = 1'b1;
    sched(4'h5, 4'hA, 20, 20);
    chk(g2, 32'h00100004);
    chk(g3, 32'h10000400);
    $display("test weighted done");
    wr(8'hB3, 8'h08);
    wr(8'hB5, 8'h02);
    wr(8'hB6, 8'h01);
    strict_mode_n = 1'b0;
    sched(4'hF, 4'hF, 15, 15);
    chk(g2, 32'h0F000000);
    chk(g3, 32'h08040201);
    sched(4'h6, 4'hF, 15, 15);
    chk(g2, 32'h000F0000);
    rd(8'hB7, 8'h88);
    rd(8'hB3, 8'h08);
    $display("test strict done");
    strict_mode_n = 1'b1;
    sched(4'hF, 4'hF, 15, 15);
    chk(g2, 32'h08040201);
    $display("test global bit done");
    final_report();
  end
endmodule // testbench
bind eqs_top eqs_top_properties eqs_top_properties_i (
  .core_clk      (core_clk),
  .nrst          (nrst),
  .reg_addr      (reg_addr),
  .reg_wr        (reg_wr),
  .reg_wdata     (reg_wdata),
  .reg_rdata     (reg_rdata),
  .strict_mode_n (strict_mode_n),
  .p2_four_queue (p2_four_queue),
  .p3_four_queue (p3_four_queue),
  .p2_pending    (p2_pending),
  .p3_pending    (p3_pending),
  .p2_grant_req  (p2_grant_req),
  .p3_grant_req  (p3_grant_req),
  .p2_grant      (p2_grant),
  .p3_grant      (p3_grant)
);
